// >>> core/irq_pkg.sv
// Constants and carrier types of the vectored interrupt handler
package irq_pkg;

   // ==========================================
   // Register addresses
   localparam logic [7:0] ADDR_TIMER_CTRL = 8'h88;
   localparam logic [7:0] ADDR_TIMER_MODE = 8'h89;
   localparam logic [7:0] ADDR_SERIAL_CTRL = 8'h98;
   localparam logic [7:0] ADDR_IRQ_EN = 8'hA8;
   localparam logic [7:0] ADDR_IRQ_PRIO = 8'hB8;
   localparam logic [7:0] ADDR_EXT_EN1 = 8'hE6;
   localparam logic [7:0] ADDR_EXT_EN2 = 8'hE7;
   localparam logic [7:0] ADDR_EXT_PRIO1 = 8'hF6;
   localparam logic [7:0] ADDR_EXT_PRIO2 = 8'hF7;

   // ==========================================
   // Field positions
   localparam int TCTL_EXT0_TRIG = 0;
   localparam int TCTL_EXT0_PEND = 1;
   localparam int TCTL_EXT1_PEND = 3;
   localparam int TCTL_T0_OVF = 5;
   localparam int TCTL_T1_OVF = 7;
   localparam int TMODE_PIN_SEL = 3;
   localparam int TMODE_WAKE_SEL = 7;
   localparam int SER_RX_BIT = 0;
   localparam int SER_TX_BIT = 1;
   localparam int IRQ_EN_GLOBAL = 7;
   localparam int EXT_EN1_USB = 1;
   localparam int EXT_EN2_VBUS = 0;

   // ==========================================
   // Reset values and read masks
   localparam logic [7:0] TCTL_RST = 8'h0A;
   localparam logic [7:0] TMODE_RST = 8'h00;
   localparam logic [7:0] SER_RST = 8'h00;
   localparam logic [7:0] IRQ_EN_RST = 8'h00;
   localparam logic [7:0] IRQ_EN_MASK = 8'h9F;
   localparam logic [7:0] IRQ_PRIO_RST = 8'h80;
   localparam logic [7:0] IRQ_PRIO_MASK = 8'h1F;
   localparam logic [7:0] EXT_RST = 8'h00;

   // ==========================================
   // Sources in fixed tie-break order
   localparam int NUM_SRC = 7;
   localparam int SRC_EXT0 = 0;
   localparam int SRC_T0 = 1;
   localparam int SRC_EXT1 = 2;
   localparam int SRC_T1 = 3;
   localparam int SRC_SER = 4;
   localparam int SRC_USB = 5;
   localparam int SRC_VBUS = 6;
   localparam logic [15:0] VEC_RESET = 16'h0000;
   localparam logic [NUM_SRC-1:0][15:0] VECTORS = {
      16'h007B, 16'h0043, 16'h0023, 16'h001B, 16'h0013, 16'h000B, 16'h0003};
   // Sources whose flag the vector call clears
   localparam logic [NUM_SRC-1:0] AUTO_CLEAR = 7'h0F;

   // ==========================================
   // Vector call carried to the CPU
   typedef struct packed {
      logic [15:0] vector;
      logic [2:0] source;
      logic high;
   } vcall_s;

endpackage : irq_pkg

// >>> core/two_level_vectored_irq_handler.sv
// Two-level vectored interrupt handler with its enable, priority and flag registers
// Behaviour
// - Seven maskable sources plus reset, two levels
// - Pending flag sets regardless of any enable
// - Enabled pending source calls vector after instruction
// - Disabled pending flag makes no request
// - Global enable bit gates every source
// - Request sampled before enable clear may still win
// - Flag still set after return re-enters routine
// - Software set of flag acts as event
// - Ext0 active low from selectable pin
// - Trigger select picks level or edge
// - Ext1 from slow-clock pairs or oscillator resume
// - Reset sets both external pending flags
// - High preempts low; nothing preempts high
// - Higher level first, then fixed order
// - Sample every clock; one cycle detect
// - After return wait one more instruction
// - Equal or higher routine running blocks request
// - Flash stall delays the call
// - Fixed vector address per source
// - Call clears external and timer flags only
// - USB cause held in its own block
// - Global enable bit 7; bits 6,5 read 0
//
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
module two_level_vectored_irq_handler #(
   parameter int ADDR_W = 8
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_we,
   input wire logic reg_re,
   output logic [7:0] reg_rdata,
   input wire logic ext_irq0_pin_a,
   input wire logic ext_irq0_pin_b,
   input wire logic lfo_tick,
   input wire logic osc_resume,
   input wire logic timer0_overflow,
   input wire logic timer1_overflow,
   input wire logic serial_rx_event,
   input wire logic serial_tx_event,
   input wire logic usb_irq,
   input wire logic vbus_irq,
   input wire logic instr_end,
   input wire logic flash_stall,
   input wire logic return_from_service,
   input wire logic call_ack,
   output logic call_req,
   output irq_pkg::vcall_s call_info,
   output logic [1:0] active_levels
);

   generate
      if (ADDR_W < 8)
      begin : g_chk
         $error("ADDR_W must be at least 8");
      end
   endgenerate

   localparam int N = irq_pkg::NUM_SRC;

   // ==========================================
   // Register state
   logic [7:0] timer_ctrl_q;
   logic [7:0] timer_mode_q;
   logic [1:0] serial_flags_q;
   logic [7:0] irq_en_q;
   logic [4:0] irq_prio_q;
   logic usb_en_q;
   logic vbus_en_q;
   logic usb_hi_q;
   logic vbus_hi_q;
   logic [ADDR_W-1:0] addr8;
   logic wr_timer_ctrl;
   logic wr_serial;

   assign wr_timer_ctrl = reg_we && reg_addr == ADDR_W'(irq_pkg::ADDR_TIMER_CTRL);
   assign wr_serial = reg_we && reg_addr == ADDR_W'(irq_pkg::ADDR_SERIAL_CTRL);
   assign addr8 = reg_addr;

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         timer_mode_q <= irq_pkg::TMODE_RST;
         irq_en_q <= irq_pkg::IRQ_EN_RST;
         irq_prio_q <= '0;
         usb_en_q <= 1'b0;
         vbus_en_q <= 1'b0;
         usb_hi_q <= 1'b0;
         vbus_hi_q <= 1'b0;
      end
      else if (reg_we)
      begin
         case (addr8)
            ADDR_W'(irq_pkg::ADDR_TIMER_MODE): timer_mode_q <= reg_wdata;
            ADDR_W'(irq_pkg::ADDR_IRQ_EN): irq_en_q <= reg_wdata & irq_pkg::IRQ_EN_MASK;
            ADDR_W'(irq_pkg::ADDR_IRQ_PRIO): irq_prio_q <= reg_wdata[4:0];
            ADDR_W'(irq_pkg::ADDR_EXT_EN1): usb_en_q <= reg_wdata[irq_pkg::EXT_EN1_USB];
            ADDR_W'(irq_pkg::ADDR_EXT_EN2): vbus_en_q <= reg_wdata[irq_pkg::EXT_EN2_VBUS];
            ADDR_W'(irq_pkg::ADDR_EXT_PRIO1): usb_hi_q <= reg_wdata[irq_pkg::EXT_EN1_USB];
            ADDR_W'(irq_pkg::ADDR_EXT_PRIO2): vbus_hi_q <= reg_wdata[irq_pkg::EXT_EN2_VBUS];
            default: ;
         endcase
      end
   end

   // ==========================================
   // External interrupt 0 pin path
   logic [1:0] pa_sync_q;
   logic [1:0] pb_sync_q;
   logic ext0_lvl_q;
   logic ext0_low;
   logic ext0_event;
   logic ext0_sel;

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         pa_sync_q <= 2'h3;
         pb_sync_q <= 2'h3;
         ext0_lvl_q <= 1'b1;
      end
      else
      begin
         pa_sync_q <= {pa_sync_q[0], ext_irq0_pin_a};
         pb_sync_q <= {pb_sync_q[0], ext_irq0_pin_b};
         ext0_lvl_q <= ext0_sel;
      end
   end

   assign ext0_sel = timer_mode_q[irq_pkg::TMODE_PIN_SEL] ? pb_sync_q[1] : pa_sync_q[1];
   assign ext0_low = !ext0_lvl_q;
   // Level mode keeps setting while low; edge mode only on the fall
   assign ext0_event = timer_ctrl_q[irq_pkg::TCTL_EXT0_TRIG]
                     ? (ext0_lvl_q && !ext0_sel)
                     : ext0_low;

   // ==========================================
   // External interrupt 1 source
   logic lfo_half_q;
   logic ext1_event;

   always_ff @(posedge clk)
   begin
      if (!nrst)
         lfo_half_q <= 1'b0;
      else if (lfo_tick)
         lfo_half_q <= !lfo_half_q;
   end

   // Fires on every second slow-clock cycle, or on wake from suspend
   assign ext1_event = timer_mode_q[irq_pkg::TMODE_WAKE_SEL] ? (lfo_tick && lfo_half_q)
                                                            : osc_resume;

   // ==========================================
   // Arbitration and call state
   logic [N-1:0] pend;
   logic [N-1:0] en;
   logic [N-1:0] hi;
   logic [N-1:0] req_hi;
   logic [N-1:0] req_lo;
   logic [N-1:0] det_hi_q;
   logic [N-1:0] det_lo_q;
   logic act_hi_q;
   logic act_lo_q;
   logic wait_one_q;
   logic call_req_q;
   irq_pkg::vcall_s call_q;
   logic [N-1:0] ack_clr;
   logic [2:0] win_idx;
   logic win_valid;
   logic win_high;

   // USB and bus-voltage causes stay in their own blocks; only levels seen here
   assign pend = {vbus_irq, usb_irq,
                  serial_flags_q[irq_pkg::SER_RX_BIT] | serial_flags_q[irq_pkg::SER_TX_BIT],
                  timer_ctrl_q[irq_pkg::TCTL_T1_OVF], timer_ctrl_q[irq_pkg::TCTL_EXT1_PEND],
                  timer_ctrl_q[irq_pkg::TCTL_T0_OVF], timer_ctrl_q[irq_pkg::TCTL_EXT0_PEND]};
   assign en = {vbus_en_q, usb_en_q, irq_en_q[4:0]};
   assign hi = {vbus_hi_q, usb_hi_q, irq_prio_q};

   genvar gi;
   generate
      for (gi = 0; gi < N; gi++)
      begin : g_src
         // Global enable gates every individual enable
         assign req_hi[gi] = pend[gi] && en[gi] && irq_en_q[irq_pkg::IRQ_EN_GLOBAL] && hi[gi];
         assign req_lo[gi] = pend[gi] && en[gi] && irq_en_q[irq_pkg::IRQ_EN_GLOBAL] && !hi[gi];
         assign ack_clr[gi] = call_ack && call_req_q && call_q.source == 3'(gi)
                              && irq_pkg::AUTO_CLEAR[gi];
      end
   endgenerate

   // One clock of detection before a call may start
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         det_hi_q <= '0;
         det_lo_q <= '0;
      end
      else
      begin
         det_hi_q <= req_hi & ~ack_clr;
         det_lo_q <= req_lo & ~ack_clr;
      end
   end

   always_comb
   begin
      win_idx = '0;
      win_valid = 1'b0;
      win_high = 1'b0;
      for (int i = N - 1; i >= 0; i--)
      begin
         if (det_lo_q[i] && !act_hi_q && !act_lo_q)
         begin
            win_idx = 3'(i);
            win_valid = 1'b1;
         end
      end
      for (int i = N - 1; i >= 0; i--)
      begin
         if (det_hi_q[i] && !act_hi_q)
         begin
            win_idx = 3'(i);
            win_valid = 1'b1;
            win_high = 1'b1;
         end
      end
   end

   // Detection register still holds pre-clear state for one clock
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         call_req_q <= 1'b0;
         call_q <= '{vector: irq_pkg::VEC_RESET, source: 3'h0, high: 1'b0};
      end
      else if (call_req_q)
      begin
         if (call_ack)
            call_req_q <= 1'b0;
      end
      else if (instr_end && !flash_stall && !wait_one_q && win_valid)
      begin
         call_req_q <= 1'b1;
         call_q.vector <= irq_pkg::VECTORS[win_idx];
         call_q.source <= win_idx;
         call_q.high <= win_high;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!nrst)
         wait_one_q <= 1'b0;
      else if (return_from_service)
         wait_one_q <= 1'b1;
      else if (instr_end && !flash_stall)
         wait_one_q <= 1'b0;
   end

   // Level stays active from call acceptance to the matching return
   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         act_hi_q <= 1'b0;
         act_lo_q <= 1'b0;
      end
      else if (call_ack && call_req_q)
      begin
         if (call_q.high)
            act_hi_q <= 1'b1;
         else
            act_lo_q <= 1'b1;
      end
      else if (return_from_service)
      begin
         if (act_hi_q)
            act_hi_q <= 1'b0;
         else
            act_lo_q <= 1'b0;
      end
   end

   // ==========================================
   // Pending flags: hardware set wins over any clear
   always_ff @(posedge clk)
   begin
      if (!nrst)
         timer_ctrl_q <= irq_pkg::TCTL_RST;
      else
      begin
         if (wr_timer_ctrl)
            timer_ctrl_q <= reg_wdata;
         else
         begin
            if (ack_clr[irq_pkg::SRC_EXT0])
               timer_ctrl_q[irq_pkg::TCTL_EXT0_PEND] <= 1'b0;
            if (ack_clr[irq_pkg::SRC_T0])
               timer_ctrl_q[irq_pkg::TCTL_T0_OVF] <= 1'b0;
            if (ack_clr[irq_pkg::SRC_EXT1])
               timer_ctrl_q[irq_pkg::TCTL_EXT1_PEND] <= 1'b0;
            if (ack_clr[irq_pkg::SRC_T1])
               timer_ctrl_q[irq_pkg::TCTL_T1_OVF] <= 1'b0;
         end
         if (ext0_event)
            timer_ctrl_q[irq_pkg::TCTL_EXT0_PEND] <= 1'b1;
         if (ext1_event)
            timer_ctrl_q[irq_pkg::TCTL_EXT1_PEND] <= 1'b1;
         if (timer0_overflow)
            timer_ctrl_q[irq_pkg::TCTL_T0_OVF] <= 1'b1;
         if (timer1_overflow)
            timer_ctrl_q[irq_pkg::TCTL_T1_OVF] <= 1'b1;
      end
   end

   // Serial flags are never cleared by the call
   always_ff @(posedge clk)
   begin
      if (!nrst)
         serial_flags_q <= irq_pkg::SER_RST[1:0];
      else
      begin
         if (wr_serial)
            serial_flags_q <= reg_wdata[1:0];
         if (serial_rx_event)
            serial_flags_q[irq_pkg::SER_RX_BIT] <= 1'b1;
         if (serial_tx_event)
            serial_flags_q[irq_pkg::SER_TX_BIT] <= 1'b1;
      end
   end

   // ==========================================
   // Read port, data one cycle after the strobe
   always_ff @(posedge clk)
   begin
      if (!nrst)
         reg_rdata <= 8'h00;
      else if (reg_re)
      begin
         case (addr8)
            ADDR_W'(irq_pkg::ADDR_TIMER_CTRL): reg_rdata <= timer_ctrl_q;
            ADDR_W'(irq_pkg::ADDR_TIMER_MODE): reg_rdata <= timer_mode_q;
            ADDR_W'(irq_pkg::ADDR_SERIAL_CTRL): reg_rdata <= {6'h00, serial_flags_q};
            ADDR_W'(irq_pkg::ADDR_IRQ_EN): reg_rdata <= irq_en_q;
            ADDR_W'(irq_pkg::ADDR_IRQ_PRIO): reg_rdata <= irq_pkg::IRQ_PRIO_RST | {3'h0, irq_prio_q};
            ADDR_W'(irq_pkg::ADDR_EXT_EN1): reg_rdata <= {6'h00, usb_en_q, 1'b0};
            ADDR_W'(irq_pkg::ADDR_EXT_EN2): reg_rdata <= {7'h00, vbus_en_q};
            ADDR_W'(irq_pkg::ADDR_EXT_PRIO1): reg_rdata <= {6'h00, usb_hi_q, 1'b0};
            ADDR_W'(irq_pkg::ADDR_EXT_PRIO2): reg_rdata <= {7'h00, vbus_hi_q};
            default: reg_rdata <= 8'h00;
         endcase
      end
      else
         reg_rdata <= 8'h00;
   end

   assign call_req = call_req_q;
   assign call_info = call_q;
   assign active_levels = {act_hi_q, act_lo_q};

endmodule : two_level_vectored_irq_handler

// >>> testbench/irq_handler_assertions.sv
// Port assertions for the vectored interrupt handler
`timescale 1ns/1ns
module irq_handler_assertions #(
   parameter int ADDR_W = 8
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic reg_re,
   input wire logic [7:0] reg_rdata,
   input wire logic instr_end,
   input wire logic flash_stall,
   input wire logic return_from_service,
   input wire logic call_ack,
   input wire logic call_req,
   input wire irq_pkg::vcall_s call_info,
   input wire logic [1:0] active_levels
);
   // ==========
   // Call path
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);

   a_call_held:
      assert property (call_req && !call_ack |=> call_req && $stable(call_info))
      else $error("call changed before ack");
   a_call_taken:
      assert property (call_req && call_ack && !return_from_service
         |=> !call_req && active_levels[$past(call_info.high)])
      else $error("ack did not mark level active");
   a_call_start:
      assert property ($rose(call_req) |-> $past(instr_end) && !$past(flash_stall))
      else $error("call not at instruction end");
   a_vector_map:
      assert property (call_req |-> call_info.source < 3'h7
         && call_info.vector == irq_pkg::VECTORS[call_info.source])
      else $error("wrong vector");
   a_level_block:
      assert property ($rose(call_req) |-> !$past(active_levels[1])
         && (call_info.high || !$past(active_levels[0])))
      else $error("call while equal level active");
   a_return_wait:
      assert property ($rose(call_req) |-> !$past(return_from_service))
      else $error("call right at return");
   a_return_level:
      assert property (return_from_service && !call_ack
         |=> active_levels == {1'b0, $past(active_levels[1]) & $past(active_levels[0])})
      else $error("return cleared wrong level");
   a_enable_read:
      assert property (reg_re && reg_addr == ADDR_W'(8'hA8) |=> reg_rdata[6:5] == 2'b00)
      else $error("unused enable bits not zero");
endmodule : irq_handler_assertions

bind two_level_vectored_irq_handler irq_handler_assertions #(.ADDR_W(ADDR_W)) i_chk (.clk(clk), .nrst(nrst),
   .reg_addr(reg_addr), .reg_re(reg_re), .reg_rdata(reg_rdata), .instr_end(instr_end), .flash_stall(flash_stall),
   .return_from_service(return_from_service), .call_ack(call_ack), .call_req(call_req), .call_info(call_info),
   .active_levels(active_levels));

// >>> testbench/cpu_partner_model.sv
// Behavioural CPU core taking vector calls and running service routines
`timescale 1ns/1ns
module cpu_partner_model (
   input wire logic clk,
   input wire logic nrst,
   input wire logic call_req,
   input wire logic stall_cmd,
   input wire logic [3:0] ack_delay,
   input wire logic [4:0] isr_len,
   output logic instr_end,
   output logic flash_stall,
   output logic return_from_service,
   output logic call_ack
);
   logic [3:0] wait_q;
   logic [4:0] left_q [2];
   logic [1:0] depth_q;
   logic odd_q;

   // ==========
   // One instruction every second cycle, none while stalled
   always @(posedge clk)
   begin
      instr_end <= 1'b0;
      return_from_service <= 1'b0;
      call_ack <= 1'b0;
      flash_stall <= stall_cmd;
      if (!nrst)
      begin
         wait_q <= 4'h0;
         depth_q <= 2'h0;
         odd_q <= 1'b0;
      end
      else if (call_req && !call_ack)
      begin
         wait_q <= wait_q + 4'h1;
         if (wait_q >= ack_delay)
         begin
            call_ack <= 1'b1;
            wait_q <= 4'h0;
            left_q[depth_q[0]] <= isr_len;
            depth_q <= depth_q + 2'h1;
         end
      end
      else if (!stall_cmd)
      begin
         odd_q <= !odd_q;
         if (odd_q && depth_q != 2'h0 && left_q[depth_q[1]] == 5'h00)
         begin
            return_from_service <= 1'b1;
            depth_q <= depth_q - 2'h1;
         end
         else if (odd_q)
         begin
            instr_end <= 1'b1;
            if (depth_q != 2'h0)
               left_q[depth_q[1]] <= left_q[depth_q[1]] - 5'h01;
         end
      end
   end
endmodule : cpu_partner_model

// >>> testbench/two_level_vectored_irq_handler_tb.sv
// Self-checking bench of the vectored interrupt handler
`timescale 1ns/1ns
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin miscompares++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module two_level_vectored_irq_handler_tb;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic we = 1'b0;
   logic re = 1'b0;
   logic re_q = 1'b0;
   logic pin_a = 1'b1;
   logic pin_b = 1'b1;
   logic [5:0] ev = 6'h00;
   logic usb = 1'b0;
   logic vbus = 1'b0;
   logic stall = 1'b0;
   logic [3:0] dly = 4'h1;
   logic [4:0] len = 5'h04;
   logic [7:0] rdata, d, e_rd;
   logic iend, fstall, ret, ack, req;
   logic [1:0] act;
   irq_pkg::vcall_s info, e_c;
   irq_pkg::vcall_s call_q [$];
   logic [7:0] rd_q [$];
   logic [15:0] vec_t [7] = '{16'h0003, 16'h000B, 16'h0013, 16'h001B, 16'h0023, 16'h0043, 16'h007B};
   logic [7:0] a_t [6] = '{8'h88, 8'h89, 8'hA8, 8'hB8, 8'hE6, 8'h55};
   logic [7:0] r_t [6] = '{8'h0A, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00};
   int miscompares = 0;
   int check_count = 0;

   always #5 clk = ~clk;

   two_level_vectored_irq_handler i_dut (.clk(clk), .nrst(nrst), .reg_addr(addr), .reg_wdata(wdata), .reg_we(we),
      .reg_re(re), .reg_rdata(rdata), .ext_irq0_pin_a(pin_a), .ext_irq0_pin_b(pin_b), .lfo_tick(ev[4]),
      .osc_resume(ev[5]), .timer0_overflow(ev[0]), .timer1_overflow(ev[1]), .serial_rx_event(ev[2]),
      .serial_tx_event(ev[3]), .usb_irq(usb), .vbus_irq(vbus), .instr_end(iend), .flash_stall(fstall),
      .return_from_service(ret), .call_ack(ack), .call_req(req), .call_info(info), .active_levels(act));
   cpu_partner_model i_cpu (.clk(clk), .nrst(nrst), .call_req(req), .stall_cmd(stall), .ack_delay(dly),
      .isr_len(len), .instr_end(iend), .flash_stall(fstall), .return_from_service(ret), .call_ack(ack));

   // ==========
   // Result watcher
   always @(posedge clk)
   begin
      re_q <= re;
      if (re_q)
      begin
         e_rd = rd_q.pop_front();
         `CHK("rdata", e_rd, rdata)
      end
      if (req && ack)
      begin
         e_c = (call_q.size() > 0) ? call_q.pop_front() : 20'hFFFFF;
         `CHK("call", e_c, info)
      end
   end

   task automatic test_done();
      if (miscompares == 0 && check_count > 0 && call_q.size() == 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : test_done

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      we <= 1'b1;
      @(posedge clk);
      we <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      re <= 1'b1;
      rd_q.push_back(v);
      @(posedge clk);
      re <= 1'b0;
   endtask : rd

   task automatic pulse(input logic [5:0] m);
      @(posedge clk);
      ev <= m;
      @(posedge clk);
      ev <= 6'h00;
   endtask : pulse

   task automatic expc(input int s, input logic hi);
      call_q.push_back({vec_t[s], 3'(s), hi});
   endtask : expc

   task automatic wt(input logic idle);
      int i;
      for (i = 0; i < 900; i++)
      begin
         @(posedge clk);
         if (call_q.size() == 0 && (!idle || (act === 2'b00 && req === 1'b0)))
            break;
      end
      if (i == 900)
      begin
         miscompares++;
         test_done();
      end
   endtask : wt

   initial
   begin
      void'($urandom(32'he98e));
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      foreach (a_t[i])
         rd(a_t[i], r_t[i]);
      repeat (3)
      begin
         d = 8'($urandom);
         wr(8'hA8, d & 8'h7F);
         rd(8'hA8, d & 8'h1F);
         wr(8'hB8, d);
         rd(8'hB8, d & 8'h1F | 8'h80);
      end
      wr(8'hB8, 8'h00);
      // Ext flags come up set, so clear them before enabling
      wr(8'h88, 8'h00);
      wr(8'hE6, 8'h02);
      wr(8'hE7, 8'h01);
      pulse(6'h01);
      rd(8'h88, 8'h20);
      expc(1, 0);
      wr(8'hA8, 8'h9F);
      wt(1);
      rd(8'h88, 8'h00);
      wr(8'hA8, 8'h9D);
      pulse(6'h01);
      rd(8'h88, 8'h20);
      // Second opcode after a global disable
      wr(8'hA8, 8'h1F);
      wr(8'hA8, 8'h1F);
      wr(8'h88, 8'h01);
      wr(8'h89, 8'h80);
      wr(8'hB8, 8'h08);
      dly <= 4'h0;
      pin_a <= 1'b0;
      pulse(6'h13);
      pulse(6'h10);
      pin_a <= 1'b1;
      expc(3, 1);
      expc(0, 0);
      expc(1, 0);
      expc(2, 0);
      wr(8'hA8, 8'h9F);
      wt(1);
      len <= 5'h14;
      expc(1, 0);
      pulse(6'h01);
      wt(0);
      expc(3, 1);
      pulse(6'h02);
      wt(1);
      len <= 5'h06;
      dly <= 4'h3;
      expc(4, 0);
      pulse(6'h0C);
      wt(0);
      rd(8'h98, 8'h03);
      expc(4, 0);
      wt(0);
      wr(8'h98, 8'h00);
      wt(1);
      usb <= 1'b1;
      expc(5, 0);
      wt(0);
      usb <= 1'b0;
      wt(1);
      vbus <= 1'b1;
      expc(6, 0);
      wt(0);
      vbus <= 1'b0;
      wt(1);
      wr(8'h89, 8'h08);
      pin_b <= 1'b0;
      expc(0, 0);
      wt(1);
      pin_b <= 1'b1;
      expc(2, 0);
      pulse(6'h20);
      wt(1);
      // Level mode sets the flag every cycle the pin stays low
      wr(8'h88, 8'h00);
      pin_b <= 1'b0;
      expc(0, 0);
      wt(0);
      pin_b <= 1'b1;
      // Let the synchroniser settle so the clear is not undone
      repeat (4) @(posedge clk);
      wr(8'h88, 8'h00);
      wt(1);
      expc(1, 0);
      wr(8'h88, 8'h20);
      wt(1);
      stall <= 1'b1;
      expc(1, 0);
      pulse(6'h01);
      repeat (20) @(posedge clk);
      `CHK("stalled call", 1'b0, req)
      stall <= 1'b0;
      wt(1);
      test_done();
   end
endmodule : two_level_vectored_irq_handler_tb
